/* design/softstart_params.svh */
// softstart_params.svh: offsets, fields, reset values and timing counts
// assumes one 125 MHz core clock and a plain strobe register port
// Operation
// RULE1: start input runs motor while supply valid
// RULE2: start removed with ramp-down time gives soft stop
// RULE3: echo contact follows start command by default
// RULE4: both buttons together select motor-controlled echo
// RULE5: motor-controlled echo closed in ramp, bypass, stop
// RULE6: startup-complete contact closes on ramp-up done
// RULE7: bypass contacts close with startup-complete contact
// RULE8: start removed opens bypass and startup-complete
// RULE9: group fault contact on supply loss or fault
// RULE10: setting and asymmetry faults need manual acknowledge
// RULE11: protection faults clear under every policy
// RULE12: supply voltage fault clears itself when gone
// RULE13: line faults not cleared by remote acknowledge
// RULE14: basic variant line faults self-clear, then restart
// RULE15: start removal acknowledges command-removal faults; code does so in the basic variant only
// RULE16: device fault cleared only by supply cycling
// RULE17: start and buttons synchronised and debounced
`ifndef SOFTSTART_PARAMS_SVH
`define SOFTSTART_PARAMS_SVH

// timing
`define SS_CLK_HZ 125000000
`define SS_DEBOUNCE_US 10000
`define SS_DEBOUNCE_CYC (`SS_DEBOUNCE_US * (`SS_CLK_HZ / 1000000))
`define SS_TICK_US 1000
`define SS_TICK_CYC (`SS_TICK_US * (`SS_CLK_HZ / 1000000))

// register word offsets
`define SS_ADDR_CTRL 8'h00
`define SS_ADDR_STATUS 8'h04
`define SS_ADDR_FAULT 8'h08
`define SS_ADDR_IRQ_STAT 8'h0C
`define SS_ADDR_IRQ_MASK 8'h10

// control fields
`define SS_CTRL_ECHO_RUN 0
`define SS_CTRL_BASIC 1
`define SS_CTRL_POLICY 2
`define SS_CTRL_RAMPDN 8
`define SS_CTRL_RESET 32'h0000_0000
`define SS_MASK_RESET 5'h00

// status fields
`define SS_STAT_STATE 0
`define SS_STAT_START 2
`define SS_STAT_SUPPLY 3
`define SS_STAT_BYPASS 4
`define SS_STAT_ECHO 5
`define SS_STAT_FAULT 6
`define SS_STAT_POLICY 8

// interrupt events
`define SS_NIRQ 5
`define SS_IRQ_START 0
`define SS_IRQ_BYPASS 1
`define SS_IRQ_STOPPED 2
`define SS_IRQ_FAULT 3
`define SS_IRQ_CLEARED 4

// fault classes: line, setting, asym, thy, byp, motor, therm, supply, device
`define SS_NFAULT 9
`define SS_CLR_MANUAL 9'h07F
`define SS_CLR_AUTO 9'h079
`define SS_CLR_REMOTE 9'h078
`define SS_CLR_SELF 9'h080
`define SS_CLR_BASIC_SELF 9'h001
`define SS_CLR_CMD 9'h010
`define SS_CLR_POWER 9'h100

`endif

/* design/softstart_pkg.sv */
// softstart_pkg.sv: types shared by the soft starter control
// assumes nothing of its surroundings
`default_nettype none
package softstart_pkg;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RAMP = 2'b01,
    ST_BYPASS = 2'b11,
    ST_STOP = 2'b10
  } state_t;
  typedef enum logic [1:0] {
    POL_MANUAL = 2'b00,
    POL_AUTO = 2'b01,
    POL_REMOTE = 2'b10
  } policy_t;
endpackage
`default_nettype wire

/* design/input_debounce.sv */
// input_debounce.sv: two-flop synchroniser and stability filter per bit
// assumes asynchronous pins and the core clock
`default_nettype none
module input_debounce #(
  parameter int WIDTH = 4,
  parameter int COUNT = 16
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LIMIT = CW'(COUNT);

  if (COUNT < 1 || WIDTH < 1) begin : g_bad
    $error("input_debounce: COUNT and WIDTH must be at least 1");
  end

  // one filter per bit; output moves only after COUNT stable samples
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    logic meta_q;
    logic sync_q;
    logic level_q;
    logic [CW-1:0] cnt_q;
    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= i_pin[b];
        sync_q <= meta_q;
      end
    end
    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        cnt_q <= '0;
        level_q <= 1'b0;
      end else if (sync_q == level_q) begin
        cnt_q <= '0;
      end else if (cnt_q >= LIMIT - CW'(1)) begin
        cnt_q <= '0;
        level_q <= sync_q;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
    assign o_level[b] = level_q;
  end
endmodule
`default_nettype wire

/* design/fault_ack_latch.sv */
// fault_ack_latch.sv: sticky fault per class with policy-dependent clearing
// assumes detect inputs and pulses on the core clock
`default_nettype none
`include "softstart_params.svh"
module fault_ack_latch
  import softstart_pkg::*;
#(
  parameter int N = `SS_NFAULT
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [N-1:0] i_detect,
  input wire policy_t i_policy,
  input wire logic i_manual_ack,
  input wire logic i_remote_ack,
  input wire logic i_cmd_removed,
  input wire logic i_basic,
  input wire logic i_supply_ok,
  output logic [N-1:0] o_fault
);
  localparam logic [N-1:0] MAN = N'(`SS_CLR_MANUAL);
  localparam logic [N-1:0] AUT = N'(`SS_CLR_AUTO);
  localparam logic [N-1:0] REM = N'(`SS_CLR_REMOTE);
  localparam logic [N-1:0] SLF = N'(`SS_CLR_SELF);
  localparam logic [N-1:0] BSL = N'(`SS_CLR_BASIC_SELF);
  localparam logic [N-1:0] CMD = N'(`SS_CLR_CMD);
  localparam logic [N-1:0] PWR = N'(`SS_CLR_POWER);

  if (N != `SS_NFAULT) begin : g_bad
    $error("fault_ack_latch: N must equal the number of fault classes");
  end

  // one latch per class; a detection in the clear cycle wins
  for (genvar k = 0; k < N; k++) begin : g_cls
    logic clr;
    assign clr = !i_detect[k] && (
      (i_policy == POL_MANUAL && i_manual_ack && MAN[k]) || // RULE10 RULE13
      (i_policy == POL_AUTO && AUT[k]) || // RULE11
      (i_policy == POL_REMOTE && i_remote_ack && REM[k]) || // RULE13
      SLF[k] || // RULE12
      (i_basic && BSL[k]) || // RULE14
      (i_basic && i_cmd_removed && CMD[k]) || // RULE15
      (!i_supply_ok && PWR[k])); // RULE16
    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        o_fault[k] <= 1'b0;
      end else if (i_detect[k]) begin
        o_fault[k] <= 1'b1;
      end else if (clr) begin
        o_fault[k] <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* design/soft_starter_control_io.sv */
// soft_starter_control_io.sv: start sequencing, output contacts, fault handling
// assumes pins are asynchronous; ramp-up done and fault detects are on i_clk
`default_nettype none
`include "softstart_params.svh"
module soft_starter_control_io
  import softstart_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = `SS_DEBOUNCE_CYC,
  parameter int TICK_CYCLES = `SS_TICK_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start_in,
  input wire logic i_ack_button,
  input wire logic i_policy_button,
  input wire logic i_supply_in,
  input wire logic i_remote_ack,
  input wire logic i_rampup_done,
  input wire logic [`SS_NFAULT-1:0] i_fault_detect,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [31:0] o_rd_data,
  output logic o_irq,
  output logic o_motor_enable,
  output logic o_soft_stop,
  output logic o_bypass_close,
  output logic o_startup_complete_contact,
  output logic o_start_echo_contact,
  output logic o_group_fault_contact
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 1 || DEBOUNCE_CYCLES < 1) begin : g_bad
    $error("soft_starter_control_io: counts must be at least 1");
  end

  // debounced pin levels
  logic [3:0] pins_db;
  logic start_db;
  logic ack_db;
  logic pol_db;
  logic supply_ok;

  // previous levels for edge detection
  logic start_prev_q;
  logic btn_both_prev_q;
  logic ack_prev_q;
  logic pol_prev_q;
  logic start_rise;
  logic start_fall;
  logic both_rise;
  logic ack_press;
  logic pol_press;

  // control register fields
  logic echo_run_q;
  logic basic_q;
  policy_t policy_q;
  logic [7:0] rampdn_q;
  logic [`SS_NIRQ-1:0] irq_mask_q;
  logic [`SS_NIRQ-1:0] irq_stat_q;
  logic [`SS_NIRQ-1:0] irq_event;

  // sequencer
  state_t state_q;
  state_t state_d;
  logic [TW-1:0] tick_cnt_q;
  logic [7:0] stop_cnt_q;
  logic stop_done;
  logic [`SS_NFAULT-1:0] fault_q;
  logic [`SS_NFAULT-1:0] fault_prev_q;
  logic fault_any;
  logic bypass_q;
  logic echo_q;
  logic group_fault_q;
  logic [31:0] rd_data_q;

  // register decode
  logic wr_ctrl;
  logic wr_mask;
  logic rd_irq;

  // start, buttons and supply pass synchroniser and debounce filter
  input_debounce #(
    .WIDTH(4),
    .COUNT(DEBOUNCE_CYCLES)
  ) u_debounce (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin({i_supply_in, i_policy_button, i_ack_button, i_start_in}), // RULE17
    .o_level(pins_db)
  );

  assign start_db = pins_db[0];
  assign ack_db = pins_db[1];
  assign pol_db = pins_db[2];
  assign supply_ok = pins_db[3];

  // edge detectors on filtered levels
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      start_prev_q <= 1'b0;
      btn_both_prev_q <= 1'b0;
      ack_prev_q <= 1'b0;
      pol_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_db;
      btn_both_prev_q <= ack_db && pol_db;
      ack_prev_q <= ack_db;
      pol_prev_q <= pol_db;
    end
  end

  assign start_rise = start_db && !start_prev_q;
  assign start_fall = !start_db && start_prev_q;
  assign both_rise = ack_db && pol_db && !btn_both_prev_q;
  // a single button acts only while the other is released
  assign ack_press = ack_db && !ack_prev_q && !pol_db;
  assign pol_press = pol_db && !pol_prev_q && !ack_db;

  // fault classes and their acknowledge table
  fault_ack_latch #(
    .N(`SS_NFAULT)
  ) u_faults (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_detect(i_fault_detect),
    .i_policy(policy_q),
    .i_manual_ack(ack_press),
    .i_remote_ack(i_remote_ack),
    .i_cmd_removed(start_fall), // RULE15
    .i_basic(basic_q),
    .i_supply_ok(supply_ok),
    .o_fault(fault_q)
  );

  assign fault_any = |fault_q;

  // register strobes
  assign wr_ctrl = i_wr_en && (i_addr == `SS_ADDR_CTRL);
  assign wr_mask = i_wr_en && (i_addr == `SS_ADDR_IRQ_MASK);
  assign rd_irq = i_rd_en && (i_addr == `SS_ADDR_IRQ_STAT);

  // echo mode: software write or both front buttons together
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      echo_run_q <= 1'(`SS_CTRL_RESET >> `SS_CTRL_ECHO_RUN);
    end else if (both_rise) begin
      echo_run_q <= 1'b1; // RULE4
    end else if (wr_ctrl) begin
      echo_run_q <= i_wr_data[`SS_CTRL_ECHO_RUN];
    end
  end

  // acknowledge policy: policy button steps manual, auto, remote
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      policy_q <= POL_MANUAL;
    end else if (pol_press) begin
      case (policy_q)
        POL_MANUAL: policy_q <= POL_AUTO;
        POL_AUTO: policy_q <= POL_REMOTE;
        default: policy_q <= POL_MANUAL;
      endcase
    end else if (wr_ctrl) begin
      case (i_wr_data[`SS_CTRL_POLICY +: 2])
        2'h1: policy_q <= POL_AUTO;
        2'h2: policy_q <= POL_REMOTE;
        default: policy_q <= POL_MANUAL;
      endcase
    end
  end

  // variant strap and ramp-down time
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      basic_q <= 1'b0;
      rampdn_q <= 8'h00;
    end else if (wr_ctrl) begin
      basic_q <= i_wr_data[`SS_CTRL_BASIC];
      rampdn_q <= i_wr_data[`SS_CTRL_RAMPDN +: 8];
    end
  end

  // interrupt mask
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      irq_mask_q <= `SS_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_q <= i_wr_data[`SS_NIRQ-1:0];
    end
  end

  // soft-stop timer: prescaled ticks counted against the ramp-down time
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      tick_cnt_q <= '0;
      stop_cnt_q <= 8'h00;
    end else if (state_q != ST_STOP) begin
      tick_cnt_q <= '0;
      stop_cnt_q <= 8'h00;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
      stop_cnt_q <= stop_cnt_q + 8'h01;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  assign stop_done = (stop_cnt_q >= rampdn_q);

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        // restart also follows a cleared fault while start is held
        if (supply_ok && start_db && !fault_any) begin
          state_d = ST_RAMP; // RULE1 RULE14
        end
      end
      ST_RAMP: begin
        if (!start_db) begin
          state_d = (rampdn_q != 8'h00) ? ST_STOP : ST_OFF; // RULE2
        end else if (i_rampup_done) begin
          state_d = ST_BYPASS; // RULE6
        end
      end
      ST_BYPASS: begin
        if (!start_db) begin
          state_d = (rampdn_q != 8'h00) ? ST_STOP : ST_OFF; // RULE2 RULE8
        end
      end
      ST_STOP: begin
        if (start_db) begin
          state_d = ST_RAMP; // RULE1
        end else if (stop_done) begin
          state_d = ST_OFF;
        end
      end
      default: state_d = ST_OFF;
    endcase
    // supply loss or any fault stops the motor at once
    if (!supply_ok || fault_any) begin
      state_d = ST_OFF; // RULE1
    end
  end

  // sequencer state
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // bypass and startup-complete contact share one flop
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      bypass_q <= 1'b0;
    end else begin
      bypass_q <= (state_d == ST_BYPASS); // RULE6 RULE7 RULE8
    end
  end

  // start-echo contact: command echo or motor-controlled
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      echo_q <= 1'b0;
    end else if (echo_run_q) begin
      echo_q <= (state_d != ST_OFF); // RULE5
    end else begin
      echo_q <= start_db && supply_ok; // RULE3
    end
  end

  // group fault: fault position while supply missing or any fault held
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      group_fault_q <= 1'b1;
    end else begin
      group_fault_q <= !supply_ok || fault_any; // RULE9
    end
  end

  // fault history for raise and clear events
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      fault_prev_q <= '0;
    end else begin
      fault_prev_q <= fault_q;
    end
  end

  // events feeding the sticky status
  always_comb begin
    irq_event = '0;
    irq_event[`SS_IRQ_START] = start_rise;
    irq_event[`SS_IRQ_BYPASS] = (state_d == ST_BYPASS) && (state_q != ST_BYPASS);
    irq_event[`SS_IRQ_STOPPED] = (state_d == ST_OFF) && (state_q != ST_OFF);
    irq_event[`SS_IRQ_FAULT] = |(fault_q & ~fault_prev_q);
    irq_event[`SS_IRQ_CLEARED] = |(~fault_q & fault_prev_q);
  end

  // sticky status, cleared by its read; a new event wins over the clear
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      irq_stat_q <= '0;
    end else if (rd_irq) begin
      irq_stat_q <= irq_event;
    end else begin
      irq_stat_q <= irq_stat_q | irq_event;
    end
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rd_data_q <= 32'h0000_0000;
    end else if (!i_rd_en) begin
      rd_data_q <= 32'h0000_0000;
    end else begin
      rd_data_q <= 32'h0000_0000;
      case (i_addr)
        `SS_ADDR_CTRL: begin
          rd_data_q[`SS_CTRL_ECHO_RUN] <= echo_run_q;
          rd_data_q[`SS_CTRL_BASIC] <= basic_q;
          rd_data_q[`SS_CTRL_POLICY +: 2] <= policy_q;
          rd_data_q[`SS_CTRL_RAMPDN +: 8] <= rampdn_q;
        end
        `SS_ADDR_STATUS: begin
          rd_data_q[`SS_STAT_STATE +: 2] <= state_q;
          rd_data_q[`SS_STAT_START] <= start_db;
          rd_data_q[`SS_STAT_SUPPLY] <= supply_ok;
          rd_data_q[`SS_STAT_BYPASS] <= bypass_q;
          rd_data_q[`SS_STAT_ECHO] <= echo_q;
          rd_data_q[`SS_STAT_FAULT] <= fault_any;
          rd_data_q[`SS_STAT_POLICY +: 2] <= policy_q;
        end
        `SS_ADDR_FAULT: rd_data_q[`SS_NFAULT-1:0] <= fault_q;
        `SS_ADDR_IRQ_STAT: rd_data_q[`SS_NIRQ-1:0] <= irq_stat_q;
        `SS_ADDR_IRQ_MASK: rd_data_q[`SS_NIRQ-1:0] <= irq_mask_q;
        default: rd_data_q <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // outputs
  assign o_rd_data = rd_data_q;
  assign o_irq = |(irq_stat_q & irq_mask_q);
  assign o_motor_enable = (state_q != ST_OFF);
  assign o_soft_stop = (state_q == ST_STOP);
  assign o_bypass_close = bypass_q;
  assign o_startup_complete_contact = bypass_q;
  assign o_start_echo_contact = echo_q;
  assign o_group_fault_contact = group_fault_q;
endmodule
`default_nettype wire

/* dv/soft_starter_control_io_sva.sv */
// soft_starter_control_io_sva.sv: port checker for the soft starter control
// assumes the top module ports and its debounce count
`default_nettype none
`include "softstart_params.svh"
module soft_starter_control_io_sva #(
  parameter int DEBOUNCE_CYCLES = 4
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start_in,
  input wire logic i_supply_in,
  input wire logic i_rampup_done,
  input wire logic [`SS_NFAULT-1:0] i_fault_detect,
  input wire logic o_motor_enable,
  input wire logic o_soft_stop,
  input wire logic o_bypass_close,
  input wire logic o_startup_complete_contact,
  input wire logic o_group_fault_contact
);
  localparam int SETTLE = DEBOUNCE_CYCLES + 6;
  int start_hi_q;
  int start_lo_q;
  int sup_hi_q;
  int sup_lo_q;
  logic ramp;
  // ramp phase seen from the outputs
  assign ramp = o_motor_enable && !o_soft_stop && !o_startup_complete_contact;
  // age of the start pin level, saturating
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      start_hi_q <= 0;
      start_lo_q <= 0;
    end else begin
      start_hi_q <= i_start_in ? start_hi_q + (start_hi_q < 999 ? 1 : 0) : 0;
      start_lo_q <= !i_start_in ? start_lo_q + (start_lo_q < 999 ? 1 : 0) : 0;
    end
  end
  // age of the supply pin level, saturating
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sup_hi_q <= 0;
      sup_lo_q <= 0;
    end else begin
      sup_hi_q <= i_supply_in ? sup_hi_q + (sup_hi_q < 999 ? 1 : 0) : 0;
      sup_lo_q <= !i_supply_in ? sup_lo_q + (sup_lo_q < 999 ? 1 : 0) : 0;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_bypass_tracks; o_bypass_close == o_startup_complete_contact; endproperty
  a_bypass_tracks: assert property (p_bypass_tracks) else $error("bypass and complete differ");
  property p_stop_drives; o_soft_stop |-> o_motor_enable; endproperty
  a_stop_drives: assert property (p_stop_drives) else $error("soft stop without motor");
  property p_drop_opens; start_lo_q >= SETTLE |-> !o_startup_complete_contact && !o_bypass_close; endproperty
  a_drop_opens: assert property (p_drop_opens) else $error("contacts stay closed");
  property p_rampup_closes;
    ramp && i_rampup_done && start_hi_q >= SETTLE && sup_hi_q >= SETTLE && i_fault_detect == '0
      && !o_group_fault_contact |-> ##[1:3] o_startup_complete_contact;
  endproperty
  a_rampup_closes: assert property (p_rampup_closes) else $error("startup contact late");
  property p_supply_loss; sup_lo_q >= SETTLE |-> o_group_fault_contact && !o_motor_enable; endproperty
  a_supply_loss: assert property (p_supply_loss) else $error("supply loss not signalled");
  property p_fault_raise; i_fault_detect != '0 |-> ##[1:3] o_group_fault_contact; endproperty
  a_fault_raise: assert property (p_fault_raise) else $error("fault contact late");
  property p_start_runs;
    start_hi_q >= SETTLE && sup_hi_q >= SETTLE && !o_group_fault_contact && i_fault_detect == '0
      |-> ##[0:3] (o_motor_enable || o_group_fault_contact);
  endproperty
  a_start_runs: assert property (p_start_runs) else $error("start held, motor idle");
  property p_debounced; $rose(o_motor_enable) |-> start_hi_q >= DEBOUNCE_CYCLES; endproperty
  a_debounced: assert property (p_debounced) else $error("start taken before filter");
  c_soft_stop: cover property (o_soft_stop);
  c_bypass: cover property (o_startup_complete_contact);
  c_fault: cover property ($rose(o_group_fault_contact));
endmodule
bind soft_starter_control_io soft_starter_control_io_sva #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) i_sva (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_start_in(i_start_in), .i_supply_in(i_supply_in),
  .i_rampup_done(i_rampup_done), .i_fault_detect(i_fault_detect), .o_motor_enable(o_motor_enable),
  .o_soft_stop(o_soft_stop), .o_bypass_close(o_bypass_close),
  .o_startup_complete_contact(o_startup_complete_contact), .o_group_fault_contact(o_group_fault_contact));
`default_nettype wire

/* dv/start_command_model.sv */
// start_command_model.sv: controller contact driving the start pin
// assumes the bench gives a command level and a bounce enable
`default_nettype none
module start_command_model (
  input wire logic i_clk,
  input wire logic i_cmd,
  input wire logic i_bounce,
  output logic o_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cmd_q = 1'b0;
  int chatter_q = 0;
  initial o_start = 1'b0;
  // contact follows the command but chatters on each change
  always @(posedge i_clk) begin
    if (i_cmd !== cmd_q) begin
      cmd_q <= i_cmd;
      chatter_q <= i_bounce ? 3 : 0;
      o_start <= i_bounce ? i_cmd : o_start;
    end else if (chatter_q > 0) begin
      chatter_q <= chatter_q - 1;
      o_start <= ~o_start;
    end else begin
      o_start <= cmd_q;
    end
  end
endmodule
`default_nettype wire

/* dv/test_soft_starter_control_io.sv */
// test_soft_starter_control_io.sv: self-checking bench for the soft starter control
// assumes short debounce and tick counts and the start command model
`default_nettype none
`include "softstart_params.svh"
module test_soft_starter_control_io;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEB = 4;
  localparam int TICK = 4;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic cmd = 1'b0;
  logic ack = 1'b0;
  logic pol = 1'b0;
  logic supply = 1'b1;
  logic remote = 1'b0;
  logic rampup = 1'b0;
  logic [8:0] detect = '0;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  wire logic start_pin;
  logic [31:0] o_rd_data;
  logic o_irq, o_motor, o_stop, o_bypass, o_done, o_echo, o_fault;
  logic [31:0] rdata;
  logic [7:0] rdn;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'h6d1c_c113;
  start_command_model i_plc (.i_clk(i_clk), .i_cmd(cmd), .i_bounce(1'b1), .o_start(start_pin));
  soft_starter_control_io #(.DEBOUNCE_CYCLES(DEB), .TICK_CYCLES(TICK)) i_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_start_in(start_pin), .i_ack_button(ack),
    .i_policy_button(pol), .i_supply_in(supply), .i_remote_ack(remote), .i_rampup_done(rampup),
    .i_fault_detect(detect), .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .o_rd_data(o_rd_data), .o_irq(o_irq), .o_motor_enable(o_motor), .o_soft_stop(o_stop),
    .o_bypass_close(o_bypass), .o_startup_complete_contact(o_done), .o_start_echo_contact(o_echo),
    .o_group_fault_contact(o_fault));
  // 125 MHz clock
  always #4 i_clk = ~i_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    rd_en <= 1'b0;
    #1 rdata = o_rd_data;
  endtask
  // bounded wait for an output level: 0 motor, 1 stop, 2 complete, 3 fault
  task automatic wait_out(input int sel, input logic val, input int lim);
    logic v;
    v = ~val;
    for (int n = 0; n < lim && v !== val; n++) begin
      @(posedge i_clk);
      #1;
      v = sel == 0 ? o_motor : sel == 1 ? o_stop : sel == 2 ? o_done : o_fault;
    end
    check(32'(v), 32'(val));
  endtask
  task automatic press(input logic a, input logic p);
    @(posedge i_clk);
    ack <= a;
    pol <= p;
    idle(DEB + 6);
    ack <= 1'b0;
    pol <= 1'b0;
    idle(DEB + 6);
  endtask
  task automatic pulse(input logic [8:0] f);
    @(posedge i_clk);
    detect <= f;
    @(posedge i_clk);
    detect <= '0;
  endtask
  function automatic logic cleared(input int c, input int p);
    if (c == 7) return 1'b1;
    if (p == 0) return c <= 6;
    if (p == 1) return c == 0 || (c >= 3 && c <= 6);
    return c >= 3 && c <= 6;
  endfunction
  // one start, ramp, bypass and stop, a soft stop only when rdn is nonzero
  task automatic run_once(input logic echo_run);
    @(posedge i_clk);
    cmd <= 1'b1;
    wait_out(0, 1'b1, DEB + 20);
    idle(2);
    check(32'(o_echo), 32'(1'b1));
    rd(`SS_ADDR_STATUS);
    check(32'(rdata[1:0]), 32'(2'b01));
    @(posedge i_clk);
    rampup <= 1'b1;
    wait_out(2, 1'b1, 4);
    check(32'(o_bypass), 32'(1'b1));
    @(posedge i_clk);
    rampup <= 1'b0;
    cmd <= 1'b0;
    wait_out(rdn != 0 ? 1 : 0, rdn != 0, DEB + 12);
    idle(2);
    check(32'(o_done | o_bypass), 32'(1'b0));
    check(32'(o_echo), 32'(echo_run && rdn != 0));
    wait_out(0, 1'b0, (rdn + 1) * TICK + 8);
    check(32'(o_echo), 32'(1'b0));
  endtask
  // watchdog
  initial begin
    idle(40000);
    bad_count++;
    results();
  end
  // main sequence
  initial begin
    idle(20);
    i_reset_n <= 1'b1;
    rdn = 8'h00;
    rd(`SS_ADDR_CTRL);
    check(rdata, `SS_CTRL_RESET);
    rd(`SS_ADDR_IRQ_MASK);
    check(rdata, 32'(`SS_MASK_RESET));
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    check(rdata, 32'h0000_0000);
    wr(`SS_ADDR_IRQ_MASK, 32'h0000_001f);
    wr(`SS_ADDR_CTRL, 32'(rdn) << 8);
    rd(`SS_ADDR_IRQ_STAT);
    idle(DEB + 6);
    run_once(1'b0);
    check(32'(o_irq), 32'(1'b1));
    rd(`SS_ADDR_IRQ_STAT);
    check(rdata, 32'h0000_0007);
    check(32'(o_irq), 32'(1'b0));
    wr(`SS_ADDR_IRQ_MASK, 32'h0000_0008);
    press(1'b1, 1'b1);
    rd(`SS_ADDR_CTRL);
    check(32'(rdata[0]), 32'(1'b1));
    rdn = 8'(1 + ($random(seed) & 3));
    wr(`SS_ADDR_CTRL, (32'(rdn) << 8) | 32'h1);
    run_once(1'b1);
    check(32'(o_irq), 32'(1'b0));
    rd(`SS_ADDR_IRQ_STAT);
    // fault classes line to supply under each acknowledge policy
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 8; c++) begin
        wr(`SS_ADDR_CTRL, (32'(rdn) << 8) | (32'(p) << 2) | 32'h1);
        pulse(9'(1 << c));
        wait_out(3, 1'b1, 4);
        idle(1 + ($random(seed) & 7));
        if (p == 0) press(1'b1, 1'b0);
        if (p == 2) begin
          @(posedge i_clk);
          remote <= 1'b1;
          @(posedge i_clk);
          remote <= 1'b0;
        end
        idle(4);
        rd(`SS_ADDR_FAULT);
        check(32'(rdata[c]), 32'(!cleared(c, p)));
        wr(`SS_ADDR_CTRL, 32'(rdn) << 8);
        press(1'b1, 1'b0);
      end
    end
    check(32'(o_irq), 32'(1'b1));
    rd(`SS_ADDR_IRQ_STAT);
    check(32'(rdata[4:3]), 32'(2'b11));
    check(32'(o_irq), 32'(1'b0));
    press(1'b0, 1'b1);
    rd(`SS_ADDR_CTRL);
    check(32'(rdata[3:2]), 32'(2'b01));
    pulse(9'h100);
    press(1'b1, 1'b0);
    rd(`SS_ADDR_FAULT);
    check(32'(rdata[8]), 32'(1'b1));
    @(posedge i_clk);
    supply <= 1'b0;
    idle(DEB + 8);
    check(32'(o_fault), 32'(1'b1));
    supply <= 1'b1;
    idle(DEB + 8);
    rd(`SS_ADDR_FAULT);
    check(32'(rdata[8]), 32'(1'b0));
    wr(`SS_ADDR_CTRL, (32'(rdn) << 8) | 32'h2);
    cmd <= 1'b1;
    wait_out(0, 1'b1, DEB + 20);
    pulse(9'h001);
    wait_out(0, 1'b0, 6);
    wait_out(0, 1'b1, 8);
    wait_out(3, 1'b0, 4);
    pulse(9'h010);
    wait_out(3, 1'b1, 4);
    idle(6);
    rd(`SS_ADDR_FAULT);
    check(32'(rdata[4]), 32'(1'b1));
    cmd <= 1'b0;
    idle(DEB + 10);
    rd(`SS_ADDR_FAULT);
    check(32'(rdata[4]), 32'(1'b0));
    results();
  end
endmodule
`default_nettype wire
